//--- rtl/qpt_top.sv
// top: quad pcm serial port, test-mode decoder and avalon registers
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Operation
// [RULE1] byte mode: each channel moves its bytes on its own syncs
// [RULE2] master uses one sync format, short or long, on every channel
// [RULE3] master makes short syncs one bit clock wide
// [RULE4] short tx: sync seen on fall, sign on next rise, off at ninth
// [RULE5] short rx: sync seen on fall, sign and seven bits on next falls
// [RULE6] long tx: sync three bits; start at later of edges, off at ninth
// [RULE7] long rx: after sync rise capture eight bits msb first on falls
// [RULE8] word mode: one channel-0 sync pulse moves a 32-bit word
// [RULE9] word mode: 32 captures on falls, transmit ch0 to ch3 on rises
// [RULE10] word mode: channel-1 sync pins give one-bit carry in last bit
// [RULE11] word mode: powered-down slot stays off, its byte dropped
// [RULE12] loopbacks and dc conversion, for one channel or all four
// [RULE13] test and powerdown pins stable 16 bit clocks before use
// [RULE14] in test, powerdown pins no longer change power state
// [RULE15] controller restores powerdown pins when leaving a test
// [RULE16] test acts only on channels already powered up
// [RULE17] test low: normal; high: pins 0,1 pick single-channel mode
// [RULE18] pins 0,1 low: pins 2,3 pick all-channel mode or invalid
// [RULE19] single-channel: pin 2 low select bit, pin 3 high bit
// [RULE20] digital loopback returns received byte, output held mid, low z
// [RULE21] analog loopback routes receive back to transmit, output high z
// [RULE22] dc conversion sends dc level, transmit filter bypassed
// [RULE23] format pin low selects byte mode, high word mode
// [RULE24] powerdown high 16 clocks: down; low 16 plus a sync: up
// [RULE25] transmit on rises, receive on falls, msb first
// [RULE26] channels not selected for test keep normal transfer
module qpt_top #(
    parameter int unsigned STABLE_MCLK = qpt_pkg::STABLE_MCLK
)(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        mclk_in,
    input  wire logic [3:0]  tx_frame_sync_in,
    input  wire logic [3:0]  rx_frame_sync_in,
    input  wire logic        serial_rx_in,
    input  wire logic        bus_format_select_in,
    input  wire logic        test_select_in,
    input  wire logic [3:0]  channel_powerdown_in,
    output logic             serial_tx_out,
    output logic             serial_tx_oe_out,
    output logic             tx_sync_carry_out,
    output logic             tx_sync_carry_oe_out,
    output logic             rx_sync_carry_out,
    output logic             rx_sync_carry_oe_out,
    output logic [3:0]       power_up_down_state_out,
    output logic [3:0]       analog_mid_out,
    output logic [3:0]       analog_hiz_out,
    output logic [3:0]       tx_filter_bypass_out,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    logic [10:0]        pin_s;
    logic               mclk_s;
    logic               dr_s;
    logic               word_s;
    logic [3:0]         fsx_s;
    logic [3:0]         fsr_s;
    logic               mclk_q;
    logic               rise;
    logic               fall;
    logic [3:0]         fsx_p_q;
    logic [3:0]         fsr_p_q;
    logic [3:0]         fsx_f_q;
    logic [3:0]         fsr_f_q;
    logic [3:0]         ch_en;
    logic [3:0]         xs;
    logic [3:0]         rs;
    logic [1:0]         fw_q [4];
    logic [1:0]         fw_d [4];
    logic               fmt_long_q;
    logic               fmt_long_d;
    logic [4:0]         tp_st;
    logic               tp_ok;
    logic               tst_on;
    logic [3:0]         channel_powerdown;
    logic [3:0]         pwr_q;
    logic [3:0]         pwr_d;
    logic [3:0]         fs_ev;
    logic [3:0]         sel;
    qpt_pkg::qpt_test_t mode;
    qpt_pkg::qpt_test_t tm_q [4];
    qpt_pkg::qpt_test_t tm_d [4];
    logic [7:0]         src [4];
    logic [4:0]         lastb;
    logic [3:0]         xa_q;
    logic [3:0]         xa_d;
    logic [3:0]         xo_q;
    logic [3:0]         xo_d;
    logic [4:0]         xi_q [4];
    logic [4:0]         xi_d [4];
    logic [7:0]         xl_q [4];
    logic [7:0]         xl_d [4];
    logic [1:0]         sl;
    logic               dx_d;
    logic               oe_d;
    logic               xc_d;
    logic               rc_d;
    logic [3:0]         ra_q;
    logic [3:0]         ra_d;
    logic [4:0]         ri_q [4];
    logic [4:0]         ri_d [4];
    logic [7:0]         rsr_q [4];
    logic [7:0]         rsr_d [4];
    logic [7:0]         rxb_q [4];
    logic [7:0]         rxb_d [4];
    logic [7:0]         txd_q [4];
    logic [7:0]         txd_d [4];
    logic [7:0]         dc_q;
    logic [7:0]         dc_d;
    logic               req;
    logic               ack_q;
    logic               ack_d;
    logic [31:0]        rd_d;

    // every pin passes two flops; equal delay keeps edges aligned
    qpt_pin_filter #(.WIDTH(11), .STABLE(STABLE_MCLK)) u_pins (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .tick_in(1'b0),
        .pins_in({bus_format_select_in, serial_rx_in, rx_frame_sync_in,
                  tx_frame_sync_in, mclk_in}),
        .sync_out(pin_s), .stable_out(), .settled_out());

    // test and powerdown levels count bit-clock rises before acting
    qpt_pin_filter #(.WIDTH(5), .STABLE(STABLE_MCLK)) u_test (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .tick_in(rise),
        .pins_in({test_select_in, channel_powerdown_in}),
        .sync_out(), .stable_out(tp_st), .settled_out(tp_ok)); // [RULE13]

    // pin fields and bit-clock edges
    assign mclk_s = pin_s[0];
    assign fsx_s  = pin_s[4:1];
    assign fsr_s  = pin_s[8:5];
    assign dr_s   = pin_s[9];
    assign word_s = pin_s[10];                  // [RULE23]
    assign rise   = mclk_s & ~mclk_q;           // [RULE25]
    assign fall   = ~mclk_s & mclk_q;
    assign tst_on = tp_st[4];
    assign channel_powerdown    = tp_st[3:0];
    assign ch_en  = word_s ? 4'h1 : 4'hf;       // [RULE8]
    assign lastb  = word_s ? 5'(qpt_pkg::WORD_BITS - 1) : 5'(qpt_pkg::BYTE_BITS - 1);

    // frame starts: short syncs sampled on falls, long ones on their rise
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            if (fmt_long_q)
            begin
                xs[c] = ch_en[c] & fsx_s[c] & ~fsx_p_q[c];          // [RULE6]
                rs[c] = ch_en[c] & fsr_s[c] & ~fsr_p_q[c];          // [RULE7]
            end
            else
            begin
                xs[c] = ch_en[c] & fall & fsx_s[c] & ~fsx_f_q[c];   // [RULE4]
                rs[c] = ch_en[c] & fall & fsr_s[c] & ~fsr_f_q[c];   // [RULE5]
            end
        end
    end

    // sync width in falls decides the common format for the next frame
    always_comb
    begin
        fmt_long_d = fmt_long_q;
        for (int c = 0; c < 4; c++)
        begin
            fw_d[c] = fw_q[c];
            if (fall)
                fw_d[c] = fsx_s[c] ? ((fw_q[c] == 2'h3) ? 2'h3 : fw_q[c] + 2'h1) : 2'h0;
            if (ch_en[c] && fsx_p_q[c] && !fsx_s[c])
                fmt_long_d = (fw_q[c] >= 2'h2);                     // [RULE2]
        end
    end

    // power state and test decode; pins are frozen out while testing
    always_comb
    begin
        pwr_d = pwr_q;
        sel   = 4'h0;
        mode  = qpt_pkg::QPT_NORMAL;
        for (int c = 0; c < 4; c++)
        begin
            fs_ev[c] = word_s ? (xs[0] | rs[0]) : (xs[c] | rs[c]);
            if (tp_ok && !tst_on)                                   // [RULE14]
            begin
                if (channel_powerdown[c])
                    pwr_d[c] = 1'b0;                                // [RULE24]
                else if (fs_ev[c])
                    pwr_d[c] = 1'b1;                                // [RULE24]
            end
        end
        if (tst_on && channel_powerdown[1:0] != qpt_pkg::SC_ALL)
        begin
            sel = 4'(4'h1 << channel_powerdown[3:2]);                             // [RULE19]
            unique case (channel_powerdown[1:0])                                  // [RULE17]
                qpt_pkg::SC_DLOOP: mode = qpt_pkg::QPT_DLOOP;
                qpt_pkg::SC_ALOOP: mode = qpt_pkg::QPT_ALOOP;
                default:           mode = qpt_pkg::QPT_DCCONV;
            endcase
        end
        else if (tst_on)
        begin
            sel = 4'hf;
            unique case (channel_powerdown[3:2])                                  // [RULE18]
                qpt_pkg::AC_DLOOP:  mode = qpt_pkg::QPT_DLOOP;
                qpt_pkg::AC_ALOOP:  mode = qpt_pkg::QPT_ALOOP;
                qpt_pkg::AC_DCCONV: mode = qpt_pkg::QPT_DCCONV;
                default:            sel  = 4'h0;
            endcase
        end
        for (int c = 0; c < 4; c++)
            tm_d[c] = (sel[c] && pwr_q[c]) ? mode : qpt_pkg::QPT_NORMAL; // [RULE12] [RULE16] [RULE26]
    end

    a_pwr_frozen: assert property (tst_on |=> $stable(pwr_q)) // [RULE14]
        else $error("power state moved during test");
    a_pwr_down: assert property (tp_ok && channel_powerdown[2] && !tst_on |=> !pwr_q[2]) // [RULE24]
        else $error("channel 2 did not power down");
    a_test_up_only: assert property (tm_q[3] != qpt_pkg::QPT_NORMAL |-> pwr_q[3]) // [RULE16]
        else $error("test active on a powered-down channel");

    // transmit byte source per channel; loopbacks reuse the last received byte
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            unique case (tm_q[c])
                qpt_pkg::QPT_DLOOP:  src[c] = rxb_q[c];             // [RULE20]
                qpt_pkg::QPT_ALOOP:  src[c] = rxb_q[c];             // [RULE21]
                qpt_pkg::QPT_DCCONV: src[c] = dc_q;                 // [RULE22]
                qpt_pkg::QPT_NORMAL: src[c] = txd_q[c];
            endcase
        end
    end

    // transmit engines: arm on a sync, drive from the next rise (at once for a long sync after the rise), off after last
    always_comb
    begin
        xa_d = xa_q;
        xo_d = xo_q;
        xi_d = xi_q;
        xl_d = xl_q;
        for (int c = 0; c < 4; c++)
        begin
            if (xs[c])
            begin
                if (word_s)
                    xl_d = src;
                else
                    xl_d[c] = src[c];                               // [RULE1]
                // long sync after the clock rose: start at once
                xa_d[c] = !(fmt_long_q && mclk_s);                  // [RULE6]
                xo_d[c] = fmt_long_q && mclk_s;
                xi_d[c] = 5'h0;
            end
            else if (rise && xa_q[c])
            begin
                xa_d[c] = 1'b0;                                     // [RULE4]
                xo_d[c] = 1'b1;
            end
            else if (rise && xo_q[c])
            begin
                if (xi_q[c] == lastb)
                    xo_d[c] = 1'b0;                                 // [RULE4] [RULE6]
                else
                    xi_d[c] = xi_q[c] + 5'h1;                       // [RULE9]
            end
        end
    end

    // pin drive, msb first; a powered-down slot keeps the line released
    always_comb
    begin
        dx_d = 1'b0;
        oe_d = 1'b0;
        sl   = xi_q[0][4:3];
        if (word_s)
        begin
            dx_d = xl_q[sl][~xi_q[0][2:0]];                         // [RULE9] [RULE25]
            oe_d = xo_q[0] & pwr_q[sl];                             // [RULE11]
        end
        else
        begin
            for (int c = 0; c < 4; c++)
            begin
                if (xo_q[c] && pwr_q[c])
                begin
                    dx_d = xl_q[c][~xi_q[c][2:0]];
                    oe_d = 1'b1;
                end
            end
        end
        // carries run whatever the power state, so a chain never stalls
        xc_d = word_s & xo_q[0] & (xi_q[0] == lastb);              // [RULE10] [RULE11]
        rc_d = word_s & ra_q[0] & (ri_q[0] == lastb);              // [RULE10]
    end

    a_tx_arm_short: assert property (!fmt_long_q && xs[0] |=> xa_q[0]) // [RULE4]
        else $error("short transmit sync did not arm");
    a_tx_long_now: assert property (fmt_long_q && xs[0] && mclk_s |=> xo_q[0]) // [RULE6]
        else $error("long transmit sync did not start at once");
    a_tx_byte_end: assert property (!word_s && $fell(xo_q[0]) |-> $past(xi_q[0]) == 5'h7) // [RULE4]
        else $error("byte transmit ended at the wrong bit");
    a_tx_word_end: assert property (word_s && $fell(xo_q[0]) |-> $past(xi_q[0]) == 5'h1f) // [RULE9]
        else $error("word transmit ended at the wrong bit");
    a_pd_slot: assert property ($past(word_s && xo_q[0] && !pwr_q[sl]) |-> !serial_tx_oe_out) // [RULE11]
        else $error("powered-down slot drove the line");
    a_carry_tx: assert property ($rose(tx_sync_carry_out) |-> $past(xi_q[0]) == 5'h1f) // [RULE10]
        else $error("transmit carry outside the last bit");

    // receive engines: capture on falls after the sync, store whole bytes
    always_comb
    begin
        ra_d  = ra_q;
        ri_d  = ri_q;
        rsr_d = rsr_q;
        rxb_d = rxb_q;
        for (int c = 0; c < 4; c++)
        begin
            if (rs[c])
            begin
                ra_d[c] = 1'b1;                                     // [RULE5] [RULE7]
                ri_d[c] = 5'h0;
            end
            else if (fall && ra_q[c])
            begin
                rsr_d[c] = {rsr_q[c][6:0], dr_s};                   // [RULE25]
                if (ri_q[c][2:0] == 3'h7 && word_s && pwr_q[ri_q[c][4:3]])
                    rxb_d[ri_q[c][4:3]] = {rsr_q[c][6:0], dr_s};    // [RULE9] [RULE11]
                else if (ri_q[c][2:0] == 3'h7 && !word_s && pwr_q[c])
                    rxb_d[c] = {rsr_q[c][6:0], dr_s};               // [RULE1] [RULE7]
                if (ri_q[c] == lastb)
                    ra_d[c] = 1'b0;
                else
                    ri_d[c] = ri_q[c] + 5'h1;
            end
        end
    end

    a_rx_store: assert property (!word_s && fall && ra_q[1] && ri_q[1] == 5'h7 // [RULE5]
        && pwr_q[1] && !rs[1] |=> rxb_q[1] == $past({rsr_q[1][6:0], dr_s}))
        else $error("received byte not stored");

    // avalon slave: one wait state, read data registered during it
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~ack_q;
    always_comb
    begin
        ack_d = req & ~ack_q;
        txd_d = txd_q;
        dc_d  = dc_q;
        rd_d  = 32'h0;
        if (avs_write_in && ack_q && avs_byteenable_in[0])
        begin
            if (avs_address_in < qpt_pkg::REG_RXD0)
                txd_d[avs_address_in[1:0]] = avs_writedata_in[7:0];
            else if (avs_address_in == qpt_pkg::REG_DCLVL)
                dc_d = avs_writedata_in[7:0];
        end
        if (avs_address_in < qpt_pkg::REG_RXD0)
            rd_d[7:0] = txd_q[avs_address_in[1:0]];
        else if (avs_address_in < qpt_pkg::REG_DCLVL)
            rd_d[7:0] = rxb_q[avs_address_in[1:0]];
        else if (avs_address_in == qpt_pkg::REG_DCLVL)
            rd_d[7:0] = dc_q;
        else if (avs_address_in == qpt_pkg::REG_STATUS)
        begin
            rd_d[qpt_pkg::ST_PWR +: 4] = pwr_q;
            rd_d[qpt_pkg::ST_FMT]      = fmt_long_q;
            rd_d[qpt_pkg::ST_WORD]     = word_s;
            for (int c = 0; c < 4; c++)
                rd_d[qpt_pkg::ST_TM + 2 * c +: 2] = tm_q[c];
        end
    end

    // analog-side controls follow the registered test function; high z also follows the power state
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            analog_mid_out[c] = tm_q[c] == qpt_pkg::QPT_DLOOP
                             || tm_q[c] == qpt_pkg::QPT_ALOOP;      // [RULE20] [RULE21]
            analog_hiz_out[c] = !pwr_q[c] || tm_q[c] == qpt_pkg::QPT_ALOOP; // [RULE21]
            tx_filter_bypass_out[c] = tm_q[c] == qpt_pkg::QPT_DCCONV;        // [RULE22]
        end
    end
    assign power_up_down_state_out = pwr_q;
    assign tx_sync_carry_oe_out    = word_s;                        // [RULE10]
    assign rx_sync_carry_oe_out    = word_s;

    // all state registers
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            mclk_q            <= 1'b0;
            fsx_p_q           <= 4'h0;
            fsr_p_q           <= 4'h0;
            fsx_f_q           <= 4'h0;
            fsr_f_q           <= 4'h0;
            fw_q              <= '{default: 2'h0};
            fmt_long_q        <= 1'b0;
            pwr_q             <= 4'h0;
            tm_q              <= '{default: qpt_pkg::QPT_NORMAL};
            xa_q              <= 4'h0;
            xo_q              <= 4'h0;
            xi_q              <= '{default: 5'h0};
            xl_q              <= '{default: 8'h00};
            ra_q              <= 4'h0;
            ri_q              <= '{default: 5'h0};
            rsr_q             <= '{default: 8'h00};
            rxb_q             <= '{default: qpt_pkg::RXB_RST};
            txd_q             <= '{default: qpt_pkg::TXD_RST};
            dc_q              <= qpt_pkg::DCLVL_RST;
            ack_q             <= 1'b0;
            avs_readdata_out  <= 32'h0;
            serial_tx_out     <= 1'b0;
            serial_tx_oe_out  <= 1'b0;
            tx_sync_carry_out <= 1'b0;
            rx_sync_carry_out <= 1'b0;
        end
        else
        begin
            mclk_q            <= mclk_s;
            fsx_p_q           <= fsx_s;
            fsr_p_q           <= fsr_s;
            fsx_f_q           <= fall ? fsx_s : fsx_f_q;
            fsr_f_q           <= fall ? fsr_s : fsr_f_q;
            fw_q              <= fw_d;
            fmt_long_q        <= fmt_long_d;
            pwr_q             <= pwr_d;
            tm_q              <= tm_d;
            xa_q              <= xa_d;
            xo_q              <= xo_d;
            xi_q              <= xi_d;
            xl_q              <= xl_d;
            ra_q              <= ra_d;
            ri_q              <= ri_d;
            rsr_q             <= rsr_d;
            rxb_q             <= rxb_d;
            txd_q             <= txd_d;
            dc_q              <= dc_d;
            ack_q             <= ack_d;
            avs_readdata_out  <= rd_d;
            serial_tx_out     <= dx_d;
            serial_tx_oe_out  <= oe_d;
            tx_sync_carry_out <= xc_d;
            rx_sync_carry_out <= rc_d;
        end
    end
endmodule

//--- inc/qpt_pkg.sv
// package: constants and types shared by the quad pcm port files
package qpt_pkg;
    localparam int unsigned NCH         = 4;
    localparam int unsigned BYTE_BITS   = 8;
    localparam int unsigned WORD_BITS   = 32;
    localparam int unsigned STABLE_MCLK = 16;
    // register word indices; byte address is four times the index
    localparam logic [3:0] REG_TXD0   = 4'h0;
    localparam logic [3:0] REG_RXD0   = 4'h4;
    localparam logic [3:0] REG_DCLVL  = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;
    // status field positions
    localparam int unsigned ST_PWR  = 0;
    localparam int unsigned ST_FMT  = 4;
    localparam int unsigned ST_WORD = 5;
    localparam int unsigned ST_TM   = 8;
    // values after reset
    localparam logic [7:0] TXD_RST   = 8'hff;
    localparam logic [7:0] DCLVL_RST = 8'h00;
    localparam logic [7:0] RXB_RST   = 8'h00;
    // test function of one channel
    typedef enum logic [1:0] {
        QPT_NORMAL = 2'h0,
        QPT_DLOOP  = 2'h1,
        QPT_ALOOP  = 2'h2,
        QPT_DCCONV = 2'h3
    } qpt_test_t;
    // single-channel codes, {powerdown_ch1, powerdown_ch0}
    localparam logic [1:0] SC_ALL    = 2'h0;
    localparam logic [1:0] SC_DLOOP  = 2'h3;
    localparam logic [1:0] SC_ALOOP  = 2'h2;
    localparam logic [1:0] SC_DCCONV = 2'h1;
    // all-channel codes, {powerdown_ch3, powerdown_ch2}
    localparam logic [1:0] AC_DLOOP  = 2'h0;
    localparam logic [1:0] AC_ALOOP  = 2'h2;
    localparam logic [1:0] AC_DCCONV = 2'h1;
endpackage

//--- rtl/qpt_pin_filter.sv
// pin synchroniser with a stability filter counted in bit-clock ticks
`timescale 1ns/1ns
module qpt_pin_filter #(
    parameter int unsigned WIDTH  = 1,
    parameter int unsigned STABLE = qpt_pkg::STABLE_MCLK
)(
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] pins_in,
    input  wire logic             tick_in,
    output logic      [WIDTH-1:0] sync_out,
    output logic      [WIDTH-1:0] stable_out,
    output logic                  settled_out
);
    localparam int unsigned   CW   = $clog2(STABLE + 1);
    localparam logic [CW-1:0] CMAX = CW'(STABLE);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;
    logic [WIDTH-1:0] stab_q;
    logic [WIDTH-1:0] stab_d;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;

    // any change restarts the count; the held value moves only when quiet
    always_comb
    begin
        cnt_d  = cnt_q;
        stab_d = stab_q;
        if (sync_q != last_q)
            cnt_d = '0;
        else if (tick_in && cnt_q != CMAX)
            cnt_d = cnt_q + 1'b1;
        if (cnt_q == CMAX && sync_q == last_q)
            stab_d = sync_q;
    end

    // meta_q feeds sync_q and nothing else
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
            stab_q <= '0;
            cnt_q  <= '0;
        end
        else
        begin
            meta_q <= pins_in;
            sync_q <= meta_q;
            last_q <= sync_q;
            stab_q <= stab_d;
            cnt_q  <= cnt_d;
        end
    end

    assign sync_out    = sync_q;
    assign stable_out  = stab_q;
    assign settled_out = (cnt_q == CMAX);
endmodule

//--- verif/qpt_hwy_model.sv
// highway model: free bit clock, short syncs, msb-first receive data
`timescale 1ns/1ns
module qpt_hwy_model (
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [1:0] ch_in,
    input  wire logic [7:0] byte_in,
    output logic            mclk_out,
    output logic [3:0]      sync_out,
    output logic            data_out,
    output logic            busy_out
);
    logic [3:0] div_q = 4'h0;
    logic [3:0] n_q   = 4'h0;
    logic [7:0] sh_q  = 8'h00;
    initial {mclk_out, sync_out, data_out, busy_out} = 7'h00;
    // six clk_in a phase, so the pin sampler sees every level
    always @(posedge clk_in)
    begin
        div_q    <= (div_q == 4'h5) ? 4'h0 : div_q + 4'h1;
        mclk_out <= mclk_out ^ (div_q == 4'h5);
        if (div_q == 4'h5 && !mclk_out)
        begin
            sync_out <= 4'h0;
            n_q      <= n_q + 4'h1;
            // released line shows the inverse, never a stale bit
            data_out <= (busy_out && n_q < 4'h8) ? sh_q[3'h7 - n_q[2:0]] : ~data_out;
            busy_out <= busy_out && n_q != 4'ha;
            if (!busy_out && go_in)
            begin
                busy_out <= 1'b1;
                sync_out <= 4'h1 << ch_in;
                sh_q     <= byte_in;
                n_q      <= 4'h0;
            end
        end
    end
endmodule

//--- verif/qpt_top_tb_top.sv
// self-checking bench for the quad pcm port
`timescale 1ns/1ns
module qpt_top_tb_top;
    logic        clk = 1'b0, rst_b = 1'b0, go = 1'b0, tst = 1'b0, rd = 1'b0, wr = 1'b0, fm = 1'b0;
    logic        mclk, busy, rxd, txd, oe, wt, cy, q = 1'b0;
    logic [1:0]  ch = 2'h0;
    logic [3:0]  sy, a = 4'h0, channel_powerdown = 4'h0, nb = 4'h0, pu, am;
    logic [7:0]  by = 8'h00, sh, b;
    logic [31:0] wd = 32'h0, rdt, t, eq[$], tq[$];
    int          fail_count = 0, n_checks = 0, cyc = 0, seed = 32'h2d95, nc = 0;
    initial
        forever #10 clk = ~clk;
    qpt_top #(.STABLE_MCLK(2)) i_dut (.clk_in(clk), .rst_b_in(rst_b), .mclk_in(mclk),
        .tx_frame_sync_in(sy), .rx_frame_sync_in(sy), .serial_rx_in(rxd),
        .bus_format_select_in(fm), .test_select_in(tst), .channel_powerdown_in(channel_powerdown),
        .serial_tx_out(txd), .serial_tx_oe_out(oe), .tx_sync_carry_out(cy),
        .tx_sync_carry_oe_out(), .rx_sync_carry_out(), .rx_sync_carry_oe_out(),
        .power_up_down_state_out(pu), .analog_mid_out(am), .analog_hiz_out(),
        .tx_filter_bypass_out(), .avs_address_in(a), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(4'h1), .avs_readdata_out(rdt),
        .avs_waitrequest_out(wt));
    qpt_hwy_model i_hwy (.clk_in(clk), .go_in(go), .ch_in(ch), .byte_in(by),
        .mclk_out(mclk), .sync_out(sy), .data_out(rxd), .busy_out(busy));
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    // a read notes its expected data, carried on the idle write bus
    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
        if (!w)
            eq.push_back(d);
        @(posedge clk);
        a  <= ad;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wt !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic frame(input logic [1:0] c, input logic [7:0] d);
        @(posedge clk);
        ch <= c;
        by <= d;
        go <= 1'b1;
        wait (busy === 1'b1);
        @(posedge clk);
        go <= 1'b0;
        wait (busy === 1'b0);
        repeat (40) @(posedge clk);
    endtask
    // read data stands only in the cycle that waitrequest is low
    always @(posedge clk)
        if (rd && wt === 1'b0)
            cmp("readdata", eq.pop_front(), rdt);
    // tx bits settle well before each bit-clock fall
    always @(negedge mclk)
    begin
        nb = (oe === 1'b1) ? nb + 4'h1 : 4'h0;
        sh = {sh[6:0], txd};
        nc += (cy === 1'b1);
        if (nb == 4'h8 && !q)
            cmp("txbyte", tq.size() ? tq.pop_front() : 'x, {24'h0, sh});
    end
    always @(posedge clk)
        if (++cyc == 20000)
        begin
            fail_count++;
            end_sim();
        end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, 4'h9, 32'h0);
        bus(1'b0, 4'h0, 32'hff);
        bus(1'b0, 4'hc, 32'h0);
        q = 1'b1;
        for (int k = 0; k < 8; k++)
            frame(k[1:0], 8'h00);
        q = 1'b0;
        bus(1'b0, 4'h9, 32'hf);
        for (int k = 0; k < 4; k++)
        begin
            t = $random(seed);
            b = $random(seed);
            tq.push_back({24'h0, t[7:0]});
            bus(1'b1, k[3:0], t);
            frame(k[1:0], b);
            bus(1'b0, 4'h4 + k[3:0], {24'h0, b});
        end
        channel_powerdown <= 4'h4;
        repeat (100) @(posedge clk);
        repeat (2) frame(2'h2, 8'h3c);
        bus(1'b0, 4'h9, 32'hb);
        $display("byte mode test done");
        tst <= 1'b1;
        channel_powerdown <= 4'hf;
        repeat (100) @(posedge clk);
        bus(1'b0, 4'h9, 32'h400b);
        cmp("powered", 32'hb, pu);
        cmp("analog mid", 32'h8, am);
        t = $random(seed);
        tq.push_back({24'h0, b});
        tq.push_back({24'h0, t[7:0]});
        frame(2'h3, t[7:0]);
        frame(2'h3, 8'h00);
        tq.push_back({24'h0, t[7:0]});
        bus(1'b1, 4'h1, t);
        frame(2'h1, 8'h00);
        tst <= 1'b0;
        channel_powerdown <= 4'h4;
        repeat (100) @(posedge clk);
        bus(1'b0, 4'h9, 32'hb);
        $display("test mode test done");
        fm <= 1'b1;
        tq.push_back({24'h0, t[7:0]});
        tq.push_back(32'h5a);
        bus(1'b1, 4'h0, t);
        bus(1'b1, 4'h3, 32'h5a);
        frame(2'h0, 8'h00);
        repeat (300) @(posedge clk);
        cmp("carries", 32'h1, nc);
        cmp("tx left", 32'h0, tq.size());
        $display("word mode test done");
        end_sim();
    end
endmodule
